// File: mps_spi_slave.v
// Purpose: 16-bit serial port slave of a motor pre-driver
// Assumes: sck at most 4 MHz, core clock 25 MHz oversamples it
// Notes: mode with sck idling high, change on fall, sample on rise
// Contract
// - chip select is active low; transfers happen only while it is low.
// - on chip select fall, start transfer and latch the outgoing word.
// - on chip select rise, commit word only if count and key are valid.
// - sck idles high; exactly 16 pulses per transfer, else invalid.
// - on sck fall, master and device present their next bits.
// - on sck rise, device samples din and master samples dout.
// - incoming word is 16 bits, msb first.
// - outgoing word is 16 bits, msb first.
// - dout is driven only while chip select is low, else released.
// - bits 15..10 of a received word form the command key.
// - an unknown key sets the command error flag, bit 7 of diag word 2.
// - each diagnostic flag word clears once the master has read it.
`timescale 1ns/1ps
`include "mps_defines.vh"
module mps_spi_slave (
  input wire core_clk_i,
  input wire srst_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire din_i,
  output wire dout_o,
  output wire dout_oe_o,
  input wire [7:0] diag1_set_i,
  output reg sample_hold_o,
  output reg short_mode_o,
  output reg [1:0] amp_gain_o,
  output reg command_error_flag_o,
  output reg word_valid_o,
  output reg [15:0] word_o
);
  wire cs_n_s;
  wire sck_s;
  wire din_s;
  reg cs_n_q;
  reg sck_q;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg [4:0] cnt_q;
  reg [7:0] diag1_q;
  reg [15:0] resp_q;
  reg cmd_err_q;
  reg [15:0] resp_d;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  mps_sync #(.RST_VAL(1'b1)) u_cs (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(cs_n_i),
    .sync_o(cs_n_s)
  );
  mps_sync #(.RST_VAL(1'b1)) u_sck (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(sck_i),
    .sync_o(sck_s)
  );
  mps_sync #(.RST_VAL(1'b1)) u_din (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(din_i),
    .sync_o(din_s)
  );

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  wire cs_fall = cs_n_q & ~cs_n_s;
  wire cs_rise = ~cs_n_q & cs_n_s;
  wire active = ~cs_n_s & ~cs_n_q;
  wire sck_rise = active & ~sck_q & sck_s;
  wire sck_fall = active & sck_q & ~sck_s;
  wire [5:0] key = rx_q[`MPS_KEY_MSB:`MPS_KEY_LSB];
  wire key_known = (key == `MPS_KEY_CMD1) | (key == `MPS_KEY_CMD2) |
    (key == `MPS_KEY_CMD3) | (key == `MPS_KEY_DIAG1) |
    (key == `MPS_KEY_DIAG2) | (key == `MPS_KEY_DIAG3);
  wire count_ok = (cnt_q == `MPS_PULSE_CNT);
  // a frame commits only with the right pulse count; the key splits good from bad
  wire commit_ok = cs_rise & count_ok & key_known;
  wire commit_bad = cs_rise & count_ok & ~key_known;

  // dout released whenever chip select is high
  assign dout_oe_o = ~cs_n_s;
  assign dout_o = tx_q[15];

  // next response word chosen by the committed key
  always @* begin
    resp_d = resp_q;
    case (key)
      // echo the settings being committed, not the ones they replace
      `MPS_KEY_CMD1: resp_d = {`MPS_ECHO_HDR1, rx_q[`MPS_CFG_HI], rx_q[`MPS_CFG_LO], 6'h00};
      `MPS_KEY_CMD2: resp_d = {`MPS_ECHO_HDR2, rx_q[`MPS_CFG_HI:`MPS_CFG_LO], 6'h00};
      `MPS_KEY_DIAG1: resp_d = {`MPS_DIAG1_HDR, diag1_q};
      `MPS_KEY_DIAG2: resp_d = {`MPS_DIAG2_HDR, cmd_err_q, 7'h00};
      `MPS_KEY_DIAG3: resp_d = {`MPS_DIAG3_HDR, 8'h00};
      default: resp_d = `MPS_ECHO_IDLE;
    endcase
  end

  // ----------------------------------------
  // edge history
  // ----------------------------------------
  // previous synchronised levels; reset to the idle high of both pins so
  // that leaving reset never looks like a select or clock edge
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      cs_n_q <= 1'b1;
      sck_q <= 1'b1;
    end else begin
      cs_n_q <= cs_n_s;
      sck_q <= sck_s;
    end
  end

  // ----------------------------------------
  // receive shift and pulse count
  // ----------------------------------------
  // counter restarts at every select fall; it saturates so that a frame
  // of 48 pulses cannot wrap back to a count that looks valid
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_q <= 16'h0000;
      cnt_q <= 5'h00;
    end else begin
      if (cs_fall) begin
        cnt_q <= 5'h00;
      end
      if (sck_rise) begin
        rx_q <= {rx_q[14:0], din_s};
        if (cnt_q != `MPS_CNT_SAT) begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // transmit shift
  // ----------------------------------------
  // the msb is presented from the select fall, so the first sck fall has
  // nothing to shift; every later fall moves the next bit up
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_q <= 16'h0000;
    end else begin
      if (cs_fall) begin
        tx_q <= resp_q;
      end else if (sck_fall && cnt_q != 5'h00) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // response for the next frame
  // ----------------------------------------
  // the answer to a frame goes out during the following frame; an
  // unknown key falls back to the idle word so no stale data leaks out
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      resp_q <= `MPS_ECHO_IDLE;
    end else begin
      if (commit_ok) begin
        resp_q <= resp_d;
      end else if (commit_bad) begin
        resp_q <= `MPS_ECHO_IDLE;
      end
    end
  end

  // ----------------------------------------
  // committed word
  // ----------------------------------------
  // valid pulses for one cycle; the word stands until the next commit
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      word_valid_o <= 1'b0;
      word_o <= 16'h0000;
    end else begin
      word_valid_o <= 1'b0;
      if (commit_ok) begin
        word_o <= rx_q;
        word_valid_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // configuration settings
  // ----------------------------------------
  // miscounted or unknown frames leave the settings untouched
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      sample_hold_o <= 1'b0;
      short_mode_o <= 1'b0;
      amp_gain_o <= 2'h0;
    end else begin
      if (commit_ok && key == `MPS_KEY_CMD1) begin
        sample_hold_o <= rx_q[`MPS_CFG_HI];
        short_mode_o <= rx_q[`MPS_CFG_LO];
      end
      if (commit_ok && key == `MPS_KEY_CMD2) begin
        amp_gain_o <= rx_q[`MPS_CFG_HI:`MPS_CFG_LO];
      end
    end
  end

  // ----------------------------------------
  // diagnostic flags
  // ----------------------------------------
  // read flags clear as their read frame commits, before the answer ships; an event in the clear cycle survives,
  // so a fault can never be lost between two reads
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      diag1_q <= 8'h00;
      cmd_err_q <= 1'b0;
      command_error_flag_o <= 1'b0;
    end else begin
      if (commit_ok && key == `MPS_KEY_DIAG1) begin
        diag1_q <= diag1_set_i;
      end else begin
        diag1_q <= diag1_q | diag1_set_i;
      end
      // a bad key and a read of its flag cannot share a frame; set first
      if (commit_bad) begin
        cmd_err_q <= 1'b1;
        command_error_flag_o <= 1'b1;
      end else if (commit_ok && key == `MPS_KEY_DIAG2) begin
        cmd_err_q <= 1'b0;
        command_error_flag_o <= 1'b0;
      end
    end
  end
endmodule

// File: mps_defines.vh
// Purpose: constants for the motor pre-driver serial port
// Assumes: 16-bit frames, key in the top six bits
// Notes: timing counts derive from the core clock rate
`ifndef MPS_DEFINES_VH
`define MPS_DEFINES_VH
`define MPS_WORD_BITS 16
`define MPS_CNT_BITS 5
`define MPS_KEY_MSB 15
`define MPS_KEY_LSB 10
`define MPS_KEY_CMD1 6'h01
`define MPS_KEY_CMD2 6'h02
`define MPS_KEY_CMD3 6'h03
`define MPS_KEY_DIAG1 6'h08
`define MPS_KEY_DIAG2 6'h10
`define MPS_KEY_DIAG3 6'h18
`define MPS_ECHO_IDLE 16'h0200
`define MPS_ECHO_HDR1 8'h04
`define MPS_ECHO_HDR2 8'h06
`define MPS_DIAG1_HDR 8'h10
`define MPS_DIAG2_HDR 8'h20
`define MPS_DIAG3_HDR 8'h30
`define MPS_CMDERR_BIT 7
`define MPS_PULSE_CNT 5'h10
`define MPS_CNT_SAT 5'h1f
`define MPS_CFG_HI 7
`define MPS_CFG_LO 6
`define MPS_CORE_HZ 25000000
`define MPS_SCK_MAX_HZ 4000000
`endif

// File: mps_sync.v
// Purpose: two-stage synchroniser for one pin input
// Assumes: pin is asynchronous to core_clk_i
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module mps_sync #(
  parameter RST_VAL = 1'b1
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire pin_i,
  output wire sync_o
);
  reg meta_q;
  reg sync_q;

  // ----------------------------------------
  // double flop
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule

// File: mps_spi_slave_monitor.sv
// Purpose: port checker for mps_spi_slave
// Assumes: two-flop pin sync plus one edge register inside the port
// Notes: bound into every instance
`timescale 1ns/1ps
module mps_spi_slave_monitor (
  input wire core_clk_i,
  input wire srst_i,
  input wire cs_n_i,
  input wire dout_oe_o,
  input wire command_error_flag_o,
  input wire word_valid_o,
  input wire [15:0] word_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // frame end and the release that must follow it
  sequence s_end; $rose(cs_n_i); endsequence
  sequence s_off; ##3 !dout_oe_o; endsequence
  a_oe_on_fall: assert property ($fell(cs_n_i) |-> ##3 dout_oe_o)
    else $error("dout not driven");
  a_oe_off_rise: assert property (s_end |-> s_off)
    else $error("dout not released");
  a_oe_idle_off: assert property (cs_n_i [*4] |-> !dout_oe_o)
    else $error("dout driven while idle");
  a_valid_pulse: assert property (word_valid_o |=> !word_valid_o)
    else $error("valid too long");
  a_valid_cs_high: assert property (word_valid_o |-> $past(cs_n_i, 3))
    else $error("commit inside frame");
  a_word_hold: assert property (!word_valid_o |-> $stable(word_o))
    else $error("word moved");
  a_err_set: assert property ($rose(command_error_flag_o) |-> $past(cs_n_i, 3))
    else $error("flag set in frame");
  a_err_clear: assert property ($fell(command_error_flag_o) |-> word_valid_o)
    else $error("flag cleared early");
endmodule
bind mps_spi_slave mps_spi_slave_monitor u_mon (.*);

// File: mps_master_model.sv
// Purpose: serial master model
// Assumes: sck phase of four core clocks
// Notes: released dout is seen as the last sampled bit inverted
`timescale 1ns/1ps
module mps_master_model (
  input wire core_clk_i,
  input wire dout_i,
  input wire dout_oe_i,
  output reg cs_n_o,
  output reg sck_o,
  output reg din_o
);
  reg last_q;
  wire line = dout_oe_i ? dout_i : ~last_q;
  // idle levels: select and clock high
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b1;
    din_o = 1'b1;
    last_q = 1'b0;
  end
  // one frame of n pulses, msb first
  task xfer(input [15:0] tx, input [4:0] n, output [15:0] rx);
    integer i;
    begin
      @(posedge core_clk_i) cs_n_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      for (i = 0; i < n; i = i + 1) begin
        sck_o <= 1'b0;
        din_o <= tx[15];
        tx = tx << 1;
        repeat (4) @(posedge core_clk_i);
        sck_o <= 1'b1; // 320 ns period
        rx = {rx[14:0], line};
        last_q <= line;
        repeat (4) @(posedge core_clk_i);
      end
      cs_n_o <= 1'b1; // gap kept by the caller
      din_o <= ~din_o;
    end
  endtask
endmodule

// File: tb_mps_spi_slave.sv
// Purpose: bench for mps_spi_slave
// Assumes: master model drives the pins
// Notes: one task per scenario
`timescale 1ns/1ps
module tb_mps_spi_slave;
  reg core_clk_i;
  reg srst_i;
  reg [7:0] diag1_set_i;
  wire cs_n, sck, din, dout, oe, sh, sm, err, vld;
  wire [1:0] gain;
  wire [15:0] word;
  reg [15:0] rx;
  integer err_count, cmp_count;
  mps_spi_slave dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck),
    .din_i(din), .dout_o(dout), .dout_oe_o(oe), .diag1_set_i(diag1_set_i), .sample_hold_o(sh),
    .short_mode_o(sm), .amp_gain_o(gain), .command_error_flag_o(err), .word_valid_o(vld),
    .word_o(word));
  mps_master_model m_u (.core_clk_i(core_clk_i), .dout_i(dout), .dout_oe_i(oe),
    .cs_n_o(cs_n), .sck_o(sck), .din_o(din));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  task chk(input [31:0] nm, input [15:0] exp, input [15:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // one frame, then a bounded watch for the commit pulse
  task frame(input [15:0] tx, input [4:0] n, input ev);
    integer k;
    reg seen;
    begin
      seen = 1'b0;
      m_u.xfer(tx, n, rx);
      for (k = 0; k < 8; k = k + 1) begin
        @(posedge core_clk_i);
        #1 if (vld === 1'b1) seen = 1'b1;
      end
      chk("vld", {15'h0, ev}, {15'h0, seen});
    end
  endtask
  task t_cfg;
    begin
      frame(16'h04c0, 5'd16, 1'b1);
      chk("cfg", 16'h0003, {14'h0, sh, sm});
      chk("word", 16'h04c0, word);
      frame(16'h0880, 5'd16, 1'b1);
      chk("gain", 16'h0002, {14'h0, gain});
      chk("echo", 16'h04c0, rx);
      frame(16'h0c00, 5'd16, 1'b1);
      chk("ech2", 16'h0680, rx);
      chk("gain", 16'h0002, {14'h0, gain});
      $display("test cfg done");
    end
  endtask
  task t_cnt;
    begin
      frame(16'h0400, 5'd15, 1'b0);
      frame(16'h0400, 5'd17, 1'b0);
      chk("cfg", 16'h0003, {14'h0, sh, sm});
      $display("test cnt done");
    end
  endtask
  task t_diag;
    begin
      frame(16'hfc00, 5'd16, 1'b0);
      chk("idle", 16'h0200, rx);
      chk("err", 16'h0001, {15'h0, err});
      frame(16'h4000, 5'd16, 1'b1);
      chk("idle", 16'h0200, rx);
      chk("err", 16'h0000, {15'h0, err});
      @(posedge core_clk_i) diag1_set_i <= 8'h81;
      @(posedge core_clk_i) diag1_set_i <= 8'h00;
      frame(16'h2000, 5'd16, 1'b1);
      chk("d2", 16'h2080, rx);
      frame(16'h2000, 5'd16, 1'b1);
      chk("d1", 16'h1081, rx);
      frame(16'h6000, 5'd16, 1'b1);
      chk("d1c", 16'h1000, rx);
      frame(16'h6000, 5'd16, 1'b1);
      chk("d3", 16'h3000, rx);
      $display("test diag done");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    err_count = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    diag1_set_i = 8'h00;
    rx = 16'h0;
    repeat (10) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    t_cfg;
    t_cnt;
    t_diag;
    complete_run;
  end
endmodule
